// ==== logic/fsps_pkg.sv ====
// shared constants, register map and types of the flash self-program sequencer
package fsps_pkg;
    // flash geometry
    localparam int unsigned FLASH_BYTES = 16384;
    localparam int unsigned ADDR_W      = 14;
    localparam int unsigned PAGE_BITS   = 9;
    localparam int unsigned BOOT_STEP   = 512;
    localparam int unsigned BOOT_OPT_W  = 4;
    localparam int unsigned LL_W        = 6;
    localparam int unsigned LL_SHIFT    = 8;
    localparam logic [PAGE_BITS-1:0] PAGE_ZERO = 9'h000;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_ADRH = 8'h08;
    localparam logic [7:0] OFS_ADRL = 8'h0C;
    localparam logic [7:0] OFS_DATA = 8'h10;
    localparam logic [7:0] OFS_CMD  = 8'h14;
    localparam logic [7:0] OFS_LLIM = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;

    // fields and reset values
    localparam int unsigned CTRL_EN_BIT = 7;
    localparam int unsigned MODE_W      = 3;
    localparam int unsigned ADRH_W      = 6;
    localparam int unsigned STAT_BUSY   = 0;
    localparam int unsigned STAT_REJ    = 1;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [7:0]  UNLOCK_FIRST  = 8'h46;
    localparam logic [7:0]  UNLOCK_SECOND = 8'hB9;
    localparam logic [1:0]  OPT_LOAD_CNT  = 2'h3;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // operation codes of the select field
    typedef enum logic [2:0] {
        OP_STANDBY = 3'b000,
        OP_READ    = 3'b001,
        OP_PROGRAM = 3'b010,
        OP_ERASE   = 3'b011
    } fsps_op_type;

    // command toward the flash array
    typedef struct packed {
        fsps_op_type       op;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } fsps_flash_cmd_type;
endpackage

// ==== logic/fsps_sequencer.sv ====
// flash self-program sequencer: register file, access checks and flash control
`timescale 1ns/1ns
`default_nettype none
module fsps_sequencer #(
    parameter int unsigned AXI_AW = 8
) (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    // axi4-lite write address and data
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [AXI_AW-1:0]           s_axi_awaddr,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    // axi4-lite write response
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    output logic [1:0]                       s_axi_bresp,
    // axi4-lite read
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    input  wire logic [AXI_AW-1:0]           s_axi_araddr,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    // option straps, static pins
    input  wire logic [fsps_pkg::BOOT_OPT_W-1:0] boot_size_opt,
    input  wire logic [fsps_pkg::LL_W-1:0]       lower_limit_opt,
    // cpu side
    input  wire logic                        cpu_in_boot_region,
    output logic                             cpu_stall,
    // flash array side
    output logic                             flash_req,
    output fsps_pkg::fsps_flash_cmd_type     flash_cmd,
    input  wire logic                        flash_ack,
    input  wire logic [7:0]                  flash_rdata
);
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_PRE    = 2'b01,
        ST_ACCESS = 2'b10
    } fsps_state_type;

    localparam int unsigned TW = fsps_pkg::ADDR_W + 1;

    // bus state
    logic              aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [AXI_AW-1:0] aw_addr_q, aw_addr_d;
    logic [7:0]        w_byte_q, w_byte_d;
    logic              w_lane_q, w_lane_d;
    logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]       rdata_q, rdata_d;
    // register and sequencer state
    logic [7:0]        ctrl_q, ctrl_d;
    logic [fsps_pkg::MODE_W-1:0] mode_q, mode_d;
    logic [fsps_pkg::ADRH_W-1:0] adrh_q, adrh_d;
    logic [7:0]        adrl_q, adrl_d, data_q, data_d;
    logic [fsps_pkg::LL_W-1:0] llim_q, llim_d;
    logic              rej_q, rej_d, req_q, req_d;
    logic [1:0]        load_cnt_q, load_cnt_d;
    fsps_state_type    state_q, state_d;
    fsps_pkg::fsps_flash_cmd_type cmd_q, cmd_d;
    // combinational helpers
    logic              wr_go, rd_go, cmd_wr, fire, accept, mapped_w, mapped_r;
    logic [fsps_pkg::BOOT_OPT_W-1:0] boot_opt;
    logic [fsps_pkg::LL_W-1:0]       ll_opt;
    logic [fsps_pkg::ADDR_W-1:0]     target;
    logic [TW-1:0]     boot_start, lower_bound;
    fsps_pkg::fsps_op_type sel_op;

    // straps are pins, so they are synchronised first
    fsps_sync #(.W(fsps_pkg::BOOT_OPT_W)) u_sync_boot (
        .core_clk (core_clk),
        .rst      (rst),
        .d        (boot_size_opt),
        .q        (boot_opt)
    );
    fsps_sync #(.W(fsps_pkg::LL_W)) u_sync_ll (
        .core_clk (core_clk),
        .rst      (rst),
        .d        (lower_limit_opt),
        .q        (ll_opt)
    );

    // bus handshakes; one write and one read in flight at most
    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready  = !w_full_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign wr_go = aw_full_q && w_full_q && !bvalid_q;
    assign rd_go = s_axi_arvalid && !rvalid_q;

    // address decode, shared by both directions
    function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
        logic [7:0] o;
        o = a[7:0];
        is_mapped = (o == fsps_pkg::OFS_CTRL) || (o == fsps_pkg::OFS_MODE) ||
                    (o == fsps_pkg::OFS_ADRH) || (o == fsps_pkg::OFS_ADRL) ||
                    (o == fsps_pkg::OFS_DATA) || (o == fsps_pkg::OFS_CMD)  ||
                    (o == fsps_pkg::OFS_LLIM) || (o == fsps_pkg::OFS_STAT);
    endfunction
    assign mapped_w = is_mapped(aw_addr_q);
    assign mapped_r = is_mapped(s_axi_araddr);

    // bus channel next state and read mux
    always_comb begin
        aw_full_d = aw_full_q;
        aw_addr_d = aw_addr_q;
        w_full_d  = w_full_q;
        w_byte_d  = w_byte_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_d = 1'b1;
            w_byte_d = s_axi_wdata[7:0];
            w_lane_d = s_axi_wstrb[0];
        end
        if (wr_go) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = mapped_w ? fsps_pkg::RESP_OKAY : fsps_pkg::RESP_DECERR;
        end
        if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
        if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d  = mapped_r ? fsps_pkg::RESP_OKAY : fsps_pkg::RESP_DECERR;
            rdata_d  = 32'h0000_0000;
            unique case (s_axi_araddr[7:0])
                fsps_pkg::OFS_CTRL: rdata_d[7:0] = ctrl_q;
                fsps_pkg::OFS_MODE: rdata_d[fsps_pkg::MODE_W-1:0] = mode_q;
                fsps_pkg::OFS_ADRH: rdata_d[fsps_pkg::ADRH_W-1:0] = adrh_q;
                fsps_pkg::OFS_ADRL: rdata_d[7:0] = adrl_q;
                fsps_pkg::OFS_DATA: rdata_d[7:0] = data_q;
                fsps_pkg::OFS_LLIM: rdata_d[fsps_pkg::LL_W-1:0] = llim_q;
                fsps_pkg::OFS_STAT: begin
                    rdata_d[fsps_pkg::STAT_BUSY] = (state_q != ST_IDLE);
                    rdata_d[fsps_pkg::STAT_REJ]  = rej_q;
                end
                default: rdata_d = 32'h0000_0000; // command register reads zero
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_full_q  <= 1'b0;
            w_byte_q  <= fsps_pkg::RST_BYTE;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= fsps_pkg::RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= fsps_pkg::RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
        end else begin
            aw_full_q <= aw_full_d;
            aw_addr_q <= aw_addr_d;
            w_full_q  <= w_full_d;
            w_byte_q  <= w_byte_d;
            w_lane_q  <= w_lane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    // unlock writes count only while idle, so a stalled cpu cannot queue one
    assign cmd_wr = wr_go && w_lane_q && (aw_addr_q[7:0] == fsps_pkg::OFS_CMD) &&
                    (state_q == ST_IDLE);
    fsps_unlock u_unlock (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (cmd_wr),
        .wr_byte  (w_byte_q),
        .fire     (fire)
    );

    // region limits in one shared array
    assign target      = {adrh_q, adrl_q};
    assign boot_start  = TW'(fsps_pkg::FLASH_BYTES) -
                         TW'(boot_opt * fsps_pkg::BOOT_STEP);
    assign lower_bound = TW'({llim_q, 8'h00});
    assign sel_op      = fsps_pkg::fsps_op_type'(mode_q);

    // a trigger is legal only inside the region this code may touch
    always_comb begin
        accept = 1'b0;
        if (ctrl_q[fsps_pkg::CTRL_EN_BIT] && (TW'(target) < boot_start)) begin
            unique case (sel_op)
                fsps_pkg::OP_READ:    accept = 1'b1;
                fsps_pkg::OP_PROGRAM,
                fsps_pkg::OP_ERASE:   accept = cpu_in_boot_region ||
                                               (TW'(target) >= lower_bound);
                default:              accept = 1'b0; // standby and unused codes
            endcase
        end
    end

    // registers and operation sequencing
    always_comb begin
        ctrl_d     = ctrl_q;
        mode_d     = mode_q;
        adrh_d     = adrh_q;
        adrl_d     = adrl_q;
        data_d     = data_q;
        llim_d     = llim_q;
        rej_d      = rej_q;
        req_d      = req_q;
        cmd_d      = cmd_q;
        state_d    = state_q;
        load_cnt_d = load_cnt_q;
        // strap load waits for the synchroniser to fill
        if (load_cnt_q != fsps_pkg::OPT_LOAD_CNT) begin
            load_cnt_d = load_cnt_q + 2'h1;
            if (load_cnt_d == fsps_pkg::OPT_LOAD_CNT) llim_d = ll_opt;
        end
        if (wr_go && w_lane_q && (state_q == ST_IDLE)) begin
            unique case (aw_addr_q[7:0])
                fsps_pkg::OFS_CTRL: ctrl_d = w_byte_q;
                fsps_pkg::OFS_MODE: mode_d = w_byte_q[fsps_pkg::MODE_W-1:0];
                fsps_pkg::OFS_ADRH: adrh_d = w_byte_q[fsps_pkg::ADRH_W-1:0];
                fsps_pkg::OFS_ADRL: adrl_d = w_byte_q;
                fsps_pkg::OFS_DATA: data_d = w_byte_q;
                fsps_pkg::OFS_LLIM: llim_d = w_byte_q[fsps_pkg::LL_W-1:0];
                default: ;
            endcase
        end
        unique case (state_q)
            ST_IDLE: begin
                if (fire && accept) begin
                    rej_d     = 1'b0;
                    req_d     = 1'b1;
                    cmd_d.op  = sel_op;
                    cmd_d.addr  = target;
                    cmd_d.wdata = data_q;
                    state_d   = ST_ACCESS;
                    if (sel_op == fsps_pkg::OP_PROGRAM) begin
                        cmd_d.op = fsps_pkg::OP_READ;
                        state_d  = ST_PRE;
                    end
                    if (sel_op == fsps_pkg::OP_ERASE) begin
                        cmd_d.addr = {target[fsps_pkg::ADDR_W-1:fsps_pkg::PAGE_BITS],
                                      fsps_pkg::PAGE_ZERO};
                    end
                end else if (fire) begin
                    rej_d = 1'b1;
                end
            end
            ST_PRE: begin
                // old contents first, so the program can only clear bits
                if (flash_ack) begin
                    cmd_d.op    = fsps_pkg::OP_PROGRAM;
                    cmd_d.wdata = data_q & flash_rdata;
                    state_d     = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (flash_ack) begin
                    req_d   = 1'b0;
                    state_d = ST_IDLE;
                    if (cmd_q.op == fsps_pkg::OP_READ) data_d = flash_rdata;
                end
            end
            default: begin
                req_d   = 1'b0;
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q     <= fsps_pkg::RST_BYTE;
            mode_q     <= '0;
            adrh_q     <= '0;
            adrl_q     <= fsps_pkg::RST_BYTE;
            data_q     <= fsps_pkg::RST_BYTE;
            llim_q     <= '0;
            rej_q      <= 1'b0;
            req_q      <= 1'b0;
            cmd_q      <= '0;
            state_q    <= ST_IDLE;
            load_cnt_q <= 2'h0;
        end else begin
            ctrl_q     <= ctrl_d;
            mode_q     <= mode_d;
            adrh_q     <= adrh_d;
            adrl_q     <= adrl_d;
            data_q     <= data_d;
            llim_q     <= llim_d;
            rej_q      <= rej_d;
            req_q      <= req_d;
            cmd_q      <= cmd_d;
            state_q    <= state_d;
            load_cnt_q <= load_cnt_d;
        end
    end

    // stall drops the cycle after the last ack, so held interrupts are served right after
    assign cpu_stall = (state_q != ST_IDLE) || fire;
    assign flash_req = req_q;
    assign flash_cmd = cmd_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_good_trigger;
        fire && accept;
    endsequence
    sequence s_bad_trigger;
        fire && !accept;
    endsequence

    a_trigger_starts: assert property (s_good_trigger |=> flash_req && cpu_stall)
        else $error("accepted trigger did not start flash access");
    a_reject_quiet: assert property (s_bad_trigger |=> !flash_req && rej_q)
        else $error("rejected trigger reached the flash");
    a_erase_aligned: assert property (flash_req && (flash_cmd.op == fsps_pkg::OP_ERASE)
        |-> (flash_cmd.addr[fsps_pkg::PAGE_BITS-1:0] == fsps_pkg::PAGE_ZERO))
        else $error("erase address not page aligned");
    a_prog_clears: assert property (flash_req && (flash_cmd.op == fsps_pkg::OP_PROGRAM)
        |-> ((flash_cmd.wdata & ~data_q) == 8'h00))
        else $error("program would set a bit");
    a_read_lands: assert property ((state_q == ST_ACCESS) && flash_ack &&
        (cmd_q.op == fsps_pkg::OP_READ) |=> (data_q == $past(flash_rdata)))
        else $error("read result missing from data register");
    a_stall_cover: assert property (flash_req |-> cpu_stall)
        else $error("flash busy while cpu runs");
    // program opens with a pre-read, so the requested code is taken from the trigger cycle
    a_app_guard: assert property ($rose(flash_req) && !$past(cpu_in_boot_region) &&
        ($past(sel_op) != fsps_pkg::OP_READ) |-> (TW'(flash_cmd.addr) >= lower_bound))
        else $error("application code modified below data region");
    a_boot_limit: assert property ($rose(flash_req) |-> (TW'(flash_cmd.addr) < boot_start))
        else $error("access reached boot region");
    a_release_idle: assert property ((state_q == ST_ACCESS) && flash_ack
        |=> !cpu_stall && !flash_req)
        else $error("stall held after completion");
endmodule
`default_nettype wire

// ==== logic/fsps_sync.sv ====
// two-flop synchroniser for static option straps
`timescale 1ns/1ns
`default_nettype none
module fsps_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // first stage feeds only the second stage
    always_comb begin
        meta_d = d;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q = sync_q;
endmodule
`default_nettype wire

// ==== logic/fsps_unlock.sv ====
// two-byte unlock detector on the trigger command register
`timescale 1ns/1ns
`default_nettype none
module fsps_unlock (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // command register writes
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_byte,
    // one-cycle start pulse
    output logic            fire
);
    typedef enum logic [0:0] {
        UL_WAIT_FIRST  = 1'b0,
        UL_WAIT_SECOND = 1'b1
    } fsps_ul_state_type;

    fsps_ul_state_type state_q;
    fsps_ul_state_type state_d;

    // a wrong byte drops back; a repeated first byte re-arms
    always_comb begin
        state_d = state_q;
        fire    = 1'b0;
        if (wr_en) begin
            unique case (state_q)
                UL_WAIT_FIRST: begin
                    if (wr_byte == fsps_pkg::UNLOCK_FIRST) state_d = UL_WAIT_SECOND;
                end
                UL_WAIT_SECOND: begin
                    if (wr_byte == fsps_pkg::UNLOCK_SECOND) begin
                        fire    = 1'b1;
                        state_d = UL_WAIT_FIRST;
                    end else if (wr_byte == fsps_pkg::UNLOCK_FIRST) begin
                        state_d = UL_WAIT_SECOND;
                    end else begin
                        state_d = UL_WAIT_FIRST;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= UL_WAIT_FIRST;
        end else begin
            state_q <= state_d;
        end
    end

    a_unlock_order: assert property (@(posedge core_clk) disable iff (rst)
        fire |-> (state_q == UL_WAIT_SECOND) && wr_en && (wr_byte == fsps_pkg::UNLOCK_SECOND))
        else $error("start pulse without full unlock sequence");
endmodule
`default_nettype wire

// ==== sim/fsps_flash_model.sv ====
// behavioural flash array on the far side of the sequencer's command link
`timescale 1ns/1ns
`default_nettype none
module fsps_flash_model (
    // clock and answer delay
    input  wire logic                         core_clk,
    input  wire logic [3:0]                   lat,
    // command link
    input  wire logic                         flash_req,
    input  wire fsps_pkg::fsps_flash_cmd_type flash_cmd,
    output logic                              flash_ack,
    output logic [7:0]                        flash_rdata
);
    logic [7:0] mem [16384];
    logic [3:0] wait_q;
    // erased array, idle link
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        wait_q = 4'h0;
        flash_ack = 1'b0;
        flash_rdata = 8'h5A;
    end
    // data flips outside the ack cycle so a stale byte never passes
    always @(posedge core_clk) begin
        flash_ack <= 1'b0;
        flash_rdata <= ~flash_rdata;
        if (flash_req && !flash_ack && wait_q < lat) begin
            wait_q <= wait_q + 4'h1;
        end else if (flash_req && !flash_ack) begin
            wait_q <= 4'h0;
            flash_ack <= 1'b1;
            case (flash_cmd.op)
                fsps_pkg::OP_READ: flash_rdata <= mem[flash_cmd.addr];
                // raw store: only-clear is the sequencer's duty
                fsps_pkg::OP_PROGRAM: mem[flash_cmd.addr] <= flash_cmd.wdata;
                fsps_pkg::OP_ERASE: begin
                    for (int i = 0; i < 512; i++) mem[{flash_cmd.addr[13:9], i[8:0]}] <= 8'hFF;
                end
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench: register tasks and flash operation sequences
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // bus, cpu and flash link signals
    logic        core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, cpu_in_boot_region, cpu_stall, flash_req, flash_ack;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, flash_rdata;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, ws, lat, boot_opt;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          bad_count, n_compared;
    fsps_pkg::fsps_flash_cmd_type flash_cmd;
    // straps: 1.5K boot region, data region from 0x3600
    fsps_sequencer u_dut (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .boot_size_opt(boot_opt),
        .lower_limit_opt(6'h36), .cpu_in_boot_region, .cpu_stall, .flash_req, .flash_cmd,
        .flash_ack, .flash_rdata);
    fsps_flash_model u_flash (.core_clk, .lat, .flash_req, .flash_cmd, .flash_ack,
        .flash_rdata);
    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic complete_run;
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            bad_count++;
        end
    endtask
    // aw and w offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 24'h0, d, ws};
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'h0, 32'(s_axi_bresp));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        @(posedge core_clk);
        {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk($sformatf("rdata %h", a), e, s_axi_rdata);
        chk("rresp", err ? 32'h3 : 32'h0, 32'(s_axi_rresp));
    endtask
    // full operation; x is the data register value expected afterwards
    task automatic op(input logic en, input logic [2:0] m, input logic [13:0] a,
                      input logic [7:0] d, input logic acc, input logic [7:0] x);
        wr(fsps_pkg::OFS_CTRL, {en, 7'h0});
        wr(fsps_pkg::OFS_MODE, {5'h0, m});
        wr(fsps_pkg::OFS_ADRH, {2'h0, a[13:8]});
        wr(fsps_pkg::OFS_ADRL, a[7:0]);
        wr(fsps_pkg::OFS_DATA, d);
        wr(fsps_pkg::OFS_CMD, fsps_pkg::UNLOCK_FIRST);
        wr(fsps_pkg::OFS_CMD, fsps_pkg::UNLOCK_SECOND);
        #1;
        chk("flash_req", 32'(acc), 32'(flash_req));
        chk("cpu_stall", 32'(acc), 32'(cpu_stall));
        while (cpu_stall) @(posedge core_clk);
        rd(fsps_pkg::OFS_DATA, 32'(x), 1'b0);
        rd(fsps_pkg::OFS_STAT, {30'h0, !acc, 1'b0}, 1'b0);
        wr(fsps_pkg::OFS_MODE, 8'h00);
        wr(fsps_pkg::OFS_CTRL, 8'h00);
    endtask
    // hang guard
    initial begin
        #40000;
        bad_count++;
        complete_run;
    end
    // main sequence
    initial begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {cpu_in_boot_region, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 49'h0;
        {s_axi_wstrb, ws, lat} = 12'h0F0;
        boot_opt = 4'h3;
        {bad_count, n_compared} = 64'h0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (5) @(posedge core_clk);
        rd(fsps_pkg::OFS_CTRL, 32'h0, 1'b0);
        rd(fsps_pkg::OFS_STAT, 32'h0, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        rd(fsps_pkg::OFS_LLIM, 32'h36, 1'b0);
        op(1, 3'h1, 14'h3600, 8'h11, 1, 8'hFF);
        op(1, 3'h2, 14'h3601, 8'hF0, 1, 8'hF0);
        op(1, 3'h1, 14'h3601, 8'h00, 1, 8'hF0);
        lat <= 4'h6;
        op(1, 3'h2, 14'h3601, 8'h0F, 1, 8'h0F);
        op(1, 3'h1, 14'h3601, 8'h00, 1, 8'h00);
        op(1, 3'h2, 14'h1000, 8'h5A, 0, 8'h5A);
        cpu_in_boot_region <= 1'b1;
        op(1, 3'h2, 14'h1000, 8'h5A, 1, 8'h5A);
        op(1, 3'h2, 14'h3A00, 8'h00, 0, 8'h00);
        op(1, 3'h1, 14'h3A00, 8'h33, 0, 8'h33);
        op(1, 3'h1, 14'h39FF, 8'h33, 1, 8'hFF);
        op(1, 3'h3, 14'h3600, 8'h00, 1, 8'h00);
        op(1, 3'h1, 14'h37FF, 8'h00, 1, 8'hFF);
        op(1, 3'h1, 14'h3601, 8'h00, 1, 8'hFF);
        op(1, 3'h1, 14'h1000, 8'h00, 1, 8'h5A);
        op(0, 3'h1, 14'h1000, 8'h00, 0, 8'h00);
        for (int m = 0; m < 8; m++) if (m == 0 || m > 3) op(1, m[2:0], 14'h3600, 0, 0, 0);
        cpu_in_boot_region <= 1'b0;
        wr(fsps_pkg::OFS_LLIM, 8'h38);
        rd(fsps_pkg::OFS_LLIM, 32'h38, 1'b0);
        op(1, 3'h2, 14'h3700, 8'h00, 0, 8'h00);
        op(1, 3'h2, 14'h3800, 8'hA5, 1, 8'hA5);
        ws = 4'h0;
        wr(fsps_pkg::OFS_ADRL, 8'h77);
        ws = 4'hF;
        rd(fsps_pkg::OFS_ADRL, 32'h0, 1'b0);
        wr(fsps_pkg::OFS_CTRL, 8'h80);
        wr(fsps_pkg::OFS_MODE, 8'h01);
        wr(fsps_pkg::OFS_CMD, fsps_pkg::UNLOCK_FIRST);
        wr(fsps_pkg::OFS_CMD, 8'h00);
        wr(fsps_pkg::OFS_CMD, fsps_pkg::UNLOCK_SECOND);
        #1;
        chk("flash_req", 32'h0, 32'(flash_req));
        op(1, 3'h1, 14'h3800, 8'h00, 1, 8'hA5);
        // no boot region: the top byte becomes reachable once the strap is synced
        boot_opt <= 4'h0;
        op(1, 3'h1, 14'h3FFF, 8'h00, 1, 8'hFF);
        complete_run;
    end
endmodule
`default_nettype wire
